// ### verilog/cfc_defines.svh
// Offsets, field positions, reset values and timing counts of the config block.
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH
`define CFC_CFG_IDX 7
`define CFC_CFG_ADDR 8'h1c
`define CFC_CFG_RST 8'h00
`define CFC_DLY_MSB 7
`define CFC_DLY_LSB 5
`define CFC_FLT_MSB 4
`define CFC_FLT_LSB 0
`define CFC_MOD_DIV 12'h002
`endif

// ### verilog/cfc_pkg.sv
// Types shared by the conversion and filter configuration block.
package cfc_pkg;
    typedef enum logic [2:0] {
        CFC_WIDEBAND,
        CFC_SINC4,
        CFC_SINC4_SINC1,
        CFC_SINC3,
        CFC_SINC3_SINC1
    } cfc_filt_t;
endpackage

// ### verilog/cfc_dly_if.sv
// Handshake between the start sequencer and the start-delay counter.
`timescale 1ns/1ps
interface cfc_dly_if;
    logic start;
    logic abort;
    logic [2:0] code;
    logic done;
    modport ctl (output start, output abort, output code, input done);
    modport dly (input start, input abort, input code, output done);
endinterface

// ### verilog/cfc_start_delay.sv
// Counts the programmed start delay in core clock cycles.
`timescale 1ns/1ps
`include "cfc_defines.svh"
module cfc_start_delay
    import cfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    cfc_dly_if.dly dly
);
    logic [11:0] cnt_r;
    logic done_r;

    // Delay length in modulator cycles for each field code.
    function automatic logic [11:0] mod_cycles(input logic [2:0] c);
        case (c)
            3'h0: mod_cycles = 12'h000;
            3'h1: mod_cycles = 12'h004;
            3'h2: mod_cycles = 12'h008;
            3'h3: mod_cycles = 12'h010;
            3'h4: mod_cycles = 12'h020;
            3'h5: mod_cycles = 12'h080;
            3'h6: mod_cycles = 12'h200;
            default: mod_cycles = 12'h400;
        endcase
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 12'h000;
            done_r <= 1'b0;
        end else if (dly.abort) begin
            cnt_r <= 12'h000;
            done_r <= 1'b0;
        end else if (dly.start) begin
            cnt_r <= 12'(mod_cycles(dly.code) * `CFC_MOD_DIV);
            done_r <= (mod_cycles(dly.code) == 12'h000);
        end else if (cnt_r != 12'h000) begin
            cnt_r <= cnt_r - 12'h001;
            done_r <= (cnt_r == 12'h001);
        end else begin
            done_r <= 1'b0;
        end
    end

    assign dly.done = done_r;
endmodule

// ### verilog/cfc_top.sv
// Conversion and filter configuration register with start-delay sequencer.
//
// Contract
// - Register at index 7 exists; all eight bits reset to zero.
// - Bits 7:5 set a delay only before the first conversion after start.
// - Delay counts modulator cycles; modulator clock is converter clock over two.
// - Delay codes 0..7 give 0,4,8,16,32,128,512,1024 modulator cycles.
// - Bits 4:0 select filter mode and oversampling ratio, read/write.
// - Codes 0..7: wideband, ratio 32 doubling up to 4096.
// - Codes 8..18: sinc4 with ratios 12,16,24,32 then doubling to 4096.
// - Code 19: sinc4 ratio 32 then sinc1 ratio 2.
// - Codes 20..27: sinc4 ratio 32 then sinc1 ratio 4 up to 1000.
// - Codes 28,29 sinc3 26667/32000; 30,31 add sinc1 ratio 3 or 5.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "cfc_defines.svh"
module cfc_top
    import cfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_start,
    output logic conv_active,
    output logic conv_first,
    output cfc_filt_t filt_mode,
    output logic [15:0] osr_main,
    output logic [9:0] osr_post
);
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} cfc_state_t;

    cfc_state_t state_r;
    logic [7:0] cfg_r;
    logic [7:0] act_r;
    logic [31:0] prdata_r;
    logic start_meta_r, start_sync_r, start_prev_r;
    logic first_r;
    cfc_filt_t mode_r;
    logic [15:0] osr_main_r;
    logic [9:0] osr_post_r;
    logic hit, wr_acc, rd_acc, rise, fall;
    cfc_dly_if dly_bus ();

    function automatic cfc_filt_t mode_of(input logic [4:0] c);
        if (c < 5'h08)
            mode_of = CFC_WIDEBAND;
        else if (c < 5'h13)
            mode_of = CFC_SINC4;
        else if (c < 5'h1c)
            mode_of = CFC_SINC4_SINC1;
        else if (c < 5'h1e)
            mode_of = CFC_SINC3;
        else
            mode_of = CFC_SINC3_SINC1;
    endfunction

    function automatic logic [15:0] main_of(input logic [4:0] c);
        case (c)
            5'h08: main_of = 16'h000c;
            5'h09: main_of = 16'h0010;
            5'h0a: main_of = 16'h0018;
            5'h1c: main_of = 16'h682b;
            5'h1d, 5'h1e, 5'h1f: main_of = 16'h7d00;
            default: begin
                if (c < 5'h08)
                    main_of = 16'h0020 << c[2:0];
                else if (c < 5'h13)
                    main_of = 16'h0020 << 4'(c - 5'h0b);
                else
                    main_of = 16'h0020;
            end
        endcase
    endfunction

    function automatic logic [9:0] post_of(input logic [4:0] c);
        case (c)
            5'h13: post_of = 10'h002;
            5'h14: post_of = 10'h004;
            5'h15: post_of = 10'h00a;
            5'h16: post_of = 10'h014;
            5'h17: post_of = 10'h028;
            5'h18: post_of = 10'h064;
            5'h19: post_of = 10'h0c8;
            5'h1a: post_of = 10'h190;
            5'h1b: post_of = 10'h3e8;
            5'h1e: post_of = 10'h003;
            5'h1f: post_of = 10'h005;
            default: post_of = 10'h000;
        endcase
    endfunction

    assign hit = (paddr == `CFC_CFG_ADDR);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            cfg_r <= `CFC_CFG_RST;
        else if (wr_acc && hit && pstrb[0])
            cfg_r <= pwdata[7:0];
    end

    // Read data is captured in the setup cycle, so the access is zero-wait.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            prdata_r <= 32'h0000_0000;
        else if (rd_acc)
            prdata_r <= hit ? {24'h00_0000, cfg_r} : 32'h0000_0000;
    end

    // Start is a pin; the first stage feeds no logic, the second and third feed the edge detect.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_meta_r <= 1'b0;
            start_sync_r <= 1'b0;
            start_prev_r <= 1'b0;
        end else begin
            start_meta_r <= conv_start;
            start_sync_r <= start_meta_r;
            start_prev_r <= start_sync_r;
        end
    end

    assign rise = start_sync_r && !start_prev_r && state_r == ST_IDLE;
    assign fall = !start_sync_r;

    assign dly_bus.start = rise;
    assign dly_bus.abort = fall && state_r == ST_DELAY;
    assign dly_bus.code = cfg_r[`CFC_DLY_MSB:`CFC_DLY_LSB];

    cfc_start_delay cfc_start_delay_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dly(dly_bus.dly)
    );

    // Delay only after a new start edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            first_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            case (state_r)
                ST_IDLE: if (rise) state_r <= ST_DELAY;
                ST_DELAY: begin
                    if (fall) begin
                        state_r <= ST_IDLE;
                    end else if (dly_bus.done) begin
                        state_r <= ST_RUN;
                        first_r <= 1'b1;
                    end
                end
                ST_RUN: if (fall) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_r <= `CFC_CFG_RST;
            mode_r <= CFC_WIDEBAND;
            osr_main_r <= 16'h0020;
            osr_post_r <= 10'h000;
        end else if (rise) begin
            act_r <= cfg_r;
            mode_r <= mode_of(cfg_r[`CFC_FLT_MSB:`CFC_FLT_LSB]);
            osr_main_r <= main_of(cfg_r[`CFC_FLT_MSB:`CFC_FLT_LSB]);
            osr_post_r <= post_of(cfg_r[`CFC_FLT_MSB:`CFC_FLT_LSB]);
        end
    end

    assign conv_active = (state_r == ST_RUN);
    assign conv_first = first_r;
    assign filt_mode = mode_r;
    assign osr_main = osr_main_r;
    assign osr_post = osr_post_r;

    // Helper logic for the checks below.
    logic seen_r;
    logic [11:0] wait_r;
    logic [4:0] fc;
    logic [11:0] dly_exp;
    assign fc = act_r[`CFC_FLT_MSB:`CFC_FLT_LSB];

    // Expected wait, two core cycles per modulator cycle.
    // Kept apart from the counter's own table so a wrong entry there shows.
    always_comb begin
        case (act_r[`CFC_DLY_MSB:`CFC_DLY_LSB])
            3'h0: dly_exp = 12'h000;
            3'h1: dly_exp = 12'h008;
            3'h2: dly_exp = 12'h010;
            3'h3: dly_exp = 12'h020;
            3'h4: dly_exp = 12'h040;
            3'h5: dly_exp = 12'h100;
            3'h6: dly_exp = 12'h400;
            default: dly_exp = 12'h800;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= 1'b0;
            wait_r <= 12'h000;
        end else begin
            seen_r <= 1'b1;
            wait_r <= (state_r == ST_DELAY) ? wait_r + 12'h001 : 12'h000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_reset_zero: assert property (!seen_r |-> cfg_r == 8'h00)
        else $error("config not zero after reset");
    a_write_store: assert property (wr_acc && hit && pstrb[0]
        |=> cfg_r == $past(pwdata[7:0])) else $error("write lost");
    a_read_back: assert property (rd_acc && hit
        |=> prdata == {24'h00_0000, $past(cfg_r)})
        else $error("read data wrong");
    a_delay_len: assert property (state_r == ST_DELAY && dly_bus.done
        |-> wait_r == dly_exp)
        else $error("start delay length wrong");
    a_mod_half: assert property ($rose(state_r == ST_DELAY)
        && act_r[7:5] == 3'h1 |-> ##8 dly_bus.done || fall)
        else $error("delay not two core cycles per modulator cycle");
    a_no_redelay: assert property (state_r == ST_RUN
        |=> state_r != ST_DELAY) else $error("later conversion delayed");
    a_wide_sel: assert property (fc < 5'h08 && !rise
        |-> mode_r == CFC_WIDEBAND && osr_main_r == 16'h0020 << fc[2:0])
        else $error("wideband decode wrong");
    a_sinc4_sel: assert property (fc >= 5'h08 && fc < 5'h13
        && !rise |-> mode_r == CFC_SINC4 && osr_post_r == 10'h000)
        else $error("sinc4 decode wrong");
    a_sinc1_two: assert property (fc == 5'h13 && !rise
        |-> osr_main_r == 16'h0020 && osr_post_r == 10'h002)
        else $error("code 19 decode wrong");
    a_sinc4_post: assert property (fc > 5'h13 && fc < 5'h1c
        && !rise |-> mode_r == CFC_SINC4_SINC1 && osr_main_r == 16'h0020)
        else $error("sinc4 plus sinc1 decode wrong");
    a_sinc3_sel: assert property (fc >= 5'h1c && !rise
        |-> osr_main_r >= 16'h682b && (mode_r == CFC_SINC3
        || mode_r == CFC_SINC3_SINC1)) else $error("sinc3 decode wrong");
    a_cfg_hold: assert property (state_r != ST_IDLE
        |=> $stable(act_r) && $stable(osr_main_r))
        else $error("settings changed mid conversion");

    c_delayed_run: cover property (state_r == ST_DELAY && act_r[7:5] != 3'h0
        ##1 dly_bus.done ##1 conv_first);
    c_zero_delay: cover property (rise && cfg_r[7:5] == 3'h0
        ##[1:3] conv_first);
    c_write_in_run: cover property (conv_active && wr_acc && hit);
    c_abort: cover property (state_r == ST_DELAY && fall);
endmodule

// ### bench/cfc_top_tb_top.sv
// Self-checking bench for the conversion and filter configuration block.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value at %0t: got %h expected %h", \
    $time, g, e); end end
module cfc_top_tb_top;
    import cfc_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, conv_start = 0, conv_active, conv_first, err;
    cfc_filt_t filt_mode, em;
    logic [15:0] osr_main, eo;
    logic [9:0] osr_post, ep;
    int err_count = 0, samples_checked = 0, cyc = 0, n, n0;
    int modc[8] = '{0, 4, 8, 16, 32, 128, 512, 1024};
    logic [9:0] post[9] = '{10'h002, 10'h004, 10'h00a, 10'h014, 10'h028,
        10'h064, 10'h0c8, 10'h190, 10'h3e8};
    cfc_top cfc_top_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_start(conv_start), .conv_active(conv_active),
        .conv_first(conv_first), .filt_mode(filt_mode),
        .osr_main(osr_main), .osr_post(osr_post));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hung handshake ends here rather than running forever.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc >= 30000) begin
            err_count++;
            close_out();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
        pwdata <= d; pstrb <= s;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic void exp_cfg(input int c);
        ep = 10'h000; eo = 16'h0020;
        if (c < 8) begin
            em = CFC_WIDEBAND; eo = 16'h0020 << c;
        end else if (c < 19) begin
            em = CFC_SINC4;
            eo = (c == 8) ? 16'h000c : (c == 9) ? 16'h0010 :
                 (c == 10) ? 16'h0018 : 16'h0020 << (c - 11);
        end else if (c < 28) begin
            em = CFC_SINC4_SINC1; ep = post[c - 19];
        end else begin
            em = (c < 30) ? CFC_SINC3 : CFC_SINC3_SINC1;
            eo = (c == 28) ? 16'h682b : 16'h7d00;
            ep = (c == 30) ? 10'h003 : (c == 31) ? 10'h005 : 10'h000;
        end
    endfunction
    // Raises the start pin and counts cycles to the first conversion.
    task automatic start_conv();
        @(posedge core_clk);
        conv_start <= 1;
        n = 0;
        while (conv_first !== 1'b1 && n < 2500) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic stop_conv();
        @(posedge core_clk);
        conv_start <= 0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_regs();
        apb(0, 8'h1c, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        apb(1, 8'h1c, 32'hffff_ffa5, 4'hf);
        apb(0, 8'h1c, 32'h0, 4'h0);
        `CHK(rd, 32'h0000_00a5)
        apb(1, 8'h1c, 32'h0000_005a, 4'he);
        apb(1, 8'h20, 32'h0000_005a, 4'hf);
        `CHK(err, 1'b1)
        apb(0, 8'h20, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        apb(0, 8'h1c, 32'h0, 4'h0);
        `CHK({rd, err}, {32'h0000_00a5, 1'b0})
        `CHK(pready, 1'b1)
    endtask
    task automatic t_filters();
        for (int c = 0; c < 32; c++) begin
            apb(1, 8'h1c, c, 4'h1);
            start_conv();
            exp_cfg(c);
            `CHK({filt_mode, osr_main, osr_post}, {em, eo, ep})
            stop_conv();
        end
    endtask
    task automatic t_delay();
        for (int d = 0; d < 8; d++) begin
            apb(1, 8'h1c, {24'h0, d[2:0], 5'h00}, 4'h1);
            start_conv();
            if (d == 0) n0 = n;
            `CHK(n - n0, 2 * modc[d])
            `CHK(conv_active, 1'b1)
            stop_conv();
        end
    endtask
    // Settings written mid-run wait for the next start; no second delay.
    task automatic t_midrun();
        apb(1, 8'h1c, 32'h0000_0013, 4'h1);
        start_conv();
        apb(1, 8'h1c, 32'h0000_001f, 4'h1);
        repeat (20) begin
            @(negedge core_clk);
            `CHK({conv_first, osr_post}, {1'b0, 10'h002})
        end
        stop_conv();
        start_conv();
        `CHK(osr_post, 10'h005)
        stop_conv();
        apb(1, 8'h1c, 32'h0000_00e0, 4'h1);
        @(posedge core_clk);
        conv_start <= 1;
        repeat (100) @(posedge core_clk);
        conv_start <= 0;
        repeat (2200) begin
            @(negedge core_clk);
            `CHK({conv_first, conv_active}, 2'b00)
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        `CHK({filt_mode, osr_main, osr_post}, {CFC_WIDEBAND, 16'h0020, 10'h0})
        rst_n <= 1;
        t_regs();
        t_filters();
        t_delay();
        t_midrun();
        close_out();
    end
endmodule
